// ===== src/pin_function_mux.sv
/*
  Pin function multiplexer for the port pins of the microcomputer.
  Chooses, per pin, between port registers, expansion bus signals and
  peripheral alternate functions, then registers every pin drive.
  Assumes port data/direction registers and peripherals live in the core
  and present their values as plain ports; pads resolve in/out/oe.
*/
`timescale 1ns/1ps
// How it works
// - Mode pin low gives single-chip or expansion; high gives microprocessor mode.
// - While reset input is low, all pins float and state returns to reset.
// - Strobe pin is data-access enable single-chip, read strobe on expansion bus.
// - Bus width pin low selects 16-bit external bus, high selects 8-bit.
// - Port zero pins set direction individually; all are inputs after reset.
// - On expansion bus, port zero drives address bits 0 to 7.
// - On expansion bus, port one drives address bits 8 to 15.
// - On expansion bus, port two drives address bits 16 to 19 and 23.
// - Port three drives write, high byte enable, latch enable, release grant.
// - Port four: bit0 hold request in, bit1 ready in, bit2 clock out.
// - In memory expansion mode only, port four bit two may stay a port.
// - Port nine may carry address bits 20 to 22 or five chip selects.
// - Port five also serves group one timers, motor outputs, key interrupts.
// - Port six also serves timer four, interrupts zero to two, group two timers.
// - Port seven also serves as analog converter inputs.
// - Port eight also serves both serial channels, converter outputs, interrupt four.
// - Port nine also serves interrupt three and motor waveform outputs.
// - Port ten carries low data byte: reads sample pins, writes drive them.
module pin_function_mux #(
  parameter int PORTS = pin_mux_pkg::NUM_PORTS,
  parameter int WIDTH = pin_mux_pkg::PORT_W
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic processor_mode_select_pin,
  input wire logic expansion_mode_req,
  input wire logic byte_width_pin,
  input wire logic [PORTS-1:0][WIDTH-1:0] port_data,
  input wire logic [PORTS-1:0][WIDTH-1:0] port_dir,
  input wire logic [PORTS-1:0][WIDTH-1:0] alt_sel,
  input wire logic [PORTS-1:0][WIDTH-1:0] alt_out,
  input wire logic [PORTS-1:0][WIDTH-1:0] alt_oe,
  input wire logic [23:0] bus_addr,
  input wire logic bus_access,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic bus_external,
  input wire logic high_byte_enable,
  input wire logic bus_ale,
  input wire logic bus_release_grant,
  input wire logic sys_clk_level,
  input wire logic port_four_bit_two_as_port,
  input wire logic addr_hi_sel,
  input wire logic [pin_mux_pkg::CS_LINES-1:0] chip_select_lines,
  input wire logic [WIDTH-1:0] bus_wdata_lo,
  input wire logic [PORTS-1:0][WIDTH-1:0] pin_in,
  output logic [PORTS-1:0][WIDTH-1:0] pin_out_r,
  output logic [PORTS-1:0][WIDTH-1:0] pin_oe_r,
  output logic [PORTS-1:0][WIDTH-1:0] port_in_r,
  output pin_mux_pkg::mode_t mode_r,
  output logic bus_16bit_r,
  output logic enable_strobe_n_r,
  output logic bus_hold_req_n_r,
  output logic bus_ready_n_r,
  output logic [WIDTH-1:0] bus_rdata_lo_r
);
  import pin_mux_pkg::*;

  // ==========================================================
  // Mode decode
  mode_t mode_nxt;
  logic expand;

  // Mode pin wins; the software bit only picks between the two low-pin modes
  always_comb begin
    if (processor_mode_select_pin) begin
      mode_nxt = MODE_MICRO;
    end else if (expansion_mode_req) begin
      mode_nxt = MODE_EXPAND;
    end else begin
      mode_nxt = MODE_SINGLE;
    end
  end

  assign expand = (mode_r != MODE_SINGLE);

  // Mode and bus width flops
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mode_r <= MODE_SINGLE;
      bus_16bit_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      // Width is sampled every cycle; a pin that moves mid-cycle is the board's fault
      bus_16bit_r <= ~byte_width_pin;
    end
  end

  // ==========================================================
  // Pin drive selection
  logic [PORTS-1:0][WIDTH-1:0] out_nxt;
  logic [PORTS-1:0][WIDTH-1:0] oe_nxt;

  always_comb begin
    // Port registers by default, all ports behave like port zero
    for (int p = 0; p < PORTS; p++) begin
      out_nxt[p] = port_data[p];
      oe_nxt[p] = port_dir[p];
    end
    // Peripheral functions take the pin over bit by bit
    for (int p = PORT_FIVE; p <= PORT_NINE; p++) begin
      for (int b = 0; b < WIDTH; b++) begin
        if (alt_sel[p][b]) begin
          out_nxt[p][b] = alt_out[p][b];
          oe_nxt[p][b] = alt_oe[p][b];
        end
      end
    end
    // Analog inputs must never be driven from the pad side
    oe_nxt[PORT_SEVEN] = port_dir[PORT_SEVEN] & ~alt_sel[PORT_SEVEN];
    if (expand) begin
      out_nxt[PORT_ZERO] = bus_addr[7:0];
      oe_nxt[PORT_ZERO] = ALL_PINS;
      out_nxt[PORT_ONE] = bus_addr[15:8];
      oe_nxt[PORT_ONE] = ALL_PINS;
      out_nxt[PORT_TWO] = {bus_addr[23], 3'h0, bus_addr[19:16]};
      oe_nxt[PORT_TWO] = PORT_TWO_MASK;
      out_nxt[PORT_THREE] = 8'h00;
      out_nxt[PORT_THREE][WR_PIN] = ~bus_wr;
      out_nxt[PORT_THREE][HIGH_BYTE_PIN] = ~high_byte_enable;
      out_nxt[PORT_THREE][ALE_PIN] = bus_ale;
      out_nxt[PORT_THREE][GRANT_PIN] = ~bus_release_grant;
      oe_nxt[PORT_THREE] = PORT_THREE_MASK;
      // Hold and ready are inputs; bit two is the clock output unless kept as a port, the rest stay ports
      oe_nxt[PORT_FOUR][HOLD_PIN] = 1'b0;
      oe_nxt[PORT_FOUR][READY_PIN] = 1'b0;
      if (!(mode_r == MODE_EXPAND && port_four_bit_two_as_port)) begin
        out_nxt[PORT_FOUR][CLK_PIN] = sys_clk_level;
        oe_nxt[PORT_FOUR][CLK_PIN] = 1'b1;
      end
      // Chip selects first, then the upper address lines override pins 0..2
      for (int b = 0; b < CS_LINES; b++) begin
        if (chip_select_lines[b] | alt_sel[PORT_NINE][b]) begin
          out_nxt[PORT_NINE][b] = alt_sel[PORT_NINE][b] ? alt_out[PORT_NINE][b]
                                                         : 1'b0;
          oe_nxt[PORT_NINE][b] = 1'b1;
        end
      end
      if (addr_hi_sel) begin
        out_nxt[PORT_NINE][2:0] = bus_addr[22:20];
        oe_nxt[PORT_NINE][2:0] = 3'h7;
      end
      // Data bus floats unless an external write is in progress
      out_nxt[PORT_TEN] = bus_wdata_lo;
      oe_nxt[PORT_TEN] = (bus_external && bus_wr) ? ALL_PINS : 8'h00;
    end
    // Pins that do not exist are never driven
    oe_nxt[PORT_TWO] = oe_nxt[PORT_TWO] & PORT_TWO_MASK;
    oe_nxt[PORT_THREE] = oe_nxt[PORT_THREE] & PORT_THREE_MASK;
    oe_nxt[PORT_NINE] = oe_nxt[PORT_NINE] & PORT_NINE_MASK;
  end

  // ==========================================================
  // Registered pad drive; every pin floats in reset
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      for (int p = 0; p < PORTS; p++) begin
        pin_out_r[p] <= OUT_RST;
        pin_oe_r[p] <= OE_RST;
      end
    end else begin
      pin_out_r <= out_nxt;
      pin_oe_r <= oe_nxt;
    end
  end

  // ==========================================================
  // Strobe pin: access enable or read strobe, both active low
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      enable_strobe_n_r <= STROBE_N_RST;
    end else begin
      enable_strobe_n_r <= expand ? ~bus_rd : ~bus_access;
    end
  end

  // ==========================================================
  // Pin sampling back to the core and the bus controller
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      port_in_r <= '0;
      bus_hold_req_n_r <= HANDSHAKE_N_RST;
      bus_ready_n_r <= HANDSHAKE_N_RST;
      bus_rdata_lo_r <= OUT_RST;
    end else begin
      port_in_r <= pin_in;
      // Handshakes read inactive outside bus modes so stray port levels cannot stall
      bus_hold_req_n_r <= expand ? pin_in[PORT_FOUR][HOLD_PIN] : 1'b1;
      bus_ready_n_r <= expand ? pin_in[PORT_FOUR][READY_PIN] : 1'b1;
      if (expand && bus_external && bus_rd) begin
        bus_rdata_lo_r <= pin_in[PORT_TEN];
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_mode_micro_pin: assert property (
    processor_mode_select_pin |=> mode_r == MODE_MICRO)
    else $error("mode pin high did not give microprocessor mode");
  a_mode_single_pin: assert property (
    !processor_mode_select_pin && !expansion_mode_req |=> mode_r == MODE_SINGLE)
    else $error("mode pin low did not give single-chip mode");
  a_reset_floats_pins: assert property (
    @(posedge clk_sys) disable iff (1'b0)
    !resetn |=> pin_oe_r == '0 && enable_strobe_n_r)
    else $error("pins driven after reset");
  a_strobe_source: assert property (
    ##1 enable_strobe_n_r == (($past(mode_r) != MODE_SINGLE) ? !$past(bus_rd)
                                                         : !$past(bus_access)))
    else $error("strobe pin not following its mode source");
  a_bus_width: assert property (
    byte_width_pin |=> !bus_16bit_r)
    else $error("high width pin did not give 8-bit bus");
  a_port_zero_dir: assert property (
    mode_r == MODE_SINGLE && mode_nxt == MODE_SINGLE
    |=> pin_oe_r[PORT_ZERO] == $past(port_dir[PORT_ZERO]))
    else $error("port zero direction not taken from register");
  a_low_address: assert property (
    expand |=> pin_out_r[PORT_ZERO] == $past(bus_addr[7:0])
            && pin_out_r[PORT_ONE] == $past(bus_addr[15:8])
            && pin_oe_r[PORT_ONE] == ALL_PINS)
    else $error("low address bits not on ports zero and one");
  a_port_two_addr: assert property (
    expand |=> pin_out_r[PORT_TWO][ADDR_TOP_PIN] == $past(bus_addr[23])
            && pin_oe_r[PORT_TWO] == PORT_TWO_MASK)
    else $error("port two address bits wrong");
  a_write_strobe: assert property (
    expand && bus_wr |=> !pin_out_r[PORT_THREE][WR_PIN] && pin_oe_r[PORT_THREE][WR_PIN])
    else $error("write strobe not asserted on port three");
  a_hold_input: assert property (
    expand |=> !pin_oe_r[PORT_FOUR][HOLD_PIN] && !pin_oe_r[PORT_FOUR][READY_PIN])
    else $error("hold or ready pin driven");
  a_clock_port: assert property (
    mode_r == MODE_MICRO |=> pin_oe_r[PORT_FOUR][CLK_PIN])
    else $error("clock pin released in microprocessor mode");
  a_addr_hi: assert property (
    expand && addr_hi_sel |=> pin_out_r[PORT_NINE][2:0] == $past(bus_addr[22:20]))
    else $error("upper address not on port nine");
  a_analog_float: assert property (
    alt_sel[PORT_SEVEN][0] |=> !pin_oe_r[PORT_SEVEN][0])
    else $error("analog input pin driven");
  a_data_read: assert property (
    expand && bus_external && bus_rd |=> bus_rdata_lo_r == $past(pin_in[PORT_TEN]))
    else $error("low data byte not sampled on read");
  a_alt_owns_pin: assert property (
    mode_r == MODE_SINGLE && mode_nxt == MODE_SINGLE && alt_sel[PORT_FIVE][0]
    |=> pin_out_r[PORT_FIVE][0] == $past(alt_out[PORT_FIVE][0]))
    else $error("alternate function did not own the pin");
  a_bus_wide: assert property (
    !byte_width_pin |=> bus_16bit_r)
    else $error("low width pin did not give 16-bit bus");
  a_port_two_low: assert property (
    expand |=> pin_out_r[PORT_TWO][3:0] == $past(bus_addr[19:16]))
    else $error("port two low address bits wrong");
  a_port_three_lines: assert property (
    expand |=> pin_out_r[PORT_THREE][HIGH_BYTE_PIN] == !$past(high_byte_enable)
            && pin_out_r[PORT_THREE][ALE_PIN] == $past(bus_ale)
            && pin_out_r[PORT_THREE][GRANT_PIN] == !$past(bus_release_grant))
    else $error("port three bus lines wrong");
  a_clock_kept_port: assert property (
    mode_r == MODE_EXPAND && port_four_bit_two_as_port
    |=> pin_out_r[PORT_FOUR][CLK_PIN] == $past(port_data[PORT_FOUR][CLK_PIN]))
    else $error("port four bit two not kept as a port");
  a_chip_select_oe: assert property (
    expand && chip_select_lines[CS_LINES-1] |=> pin_oe_r[PORT_NINE][CS_LINES-1])
    else $error("chip select pin not driven");
  a_missing_pins: assert property (
    (pin_oe_r[PORT_TWO] & ~PORT_TWO_MASK) == 8'h00
    && (pin_oe_r[PORT_THREE] & ~PORT_THREE_MASK) == 8'h00
    && (pin_oe_r[PORT_NINE] & ~PORT_NINE_MASK) == 8'h00)
    else $error("pin that does not exist is driven");
  a_alt_port_six: assert property (
    alt_sel[PORT_SIX][0] |=> pin_out_r[PORT_SIX][0] == $past(alt_out[PORT_SIX][0])
                          && pin_oe_r[PORT_SIX][0] == $past(alt_oe[PORT_SIX][0]))
    else $error("port six alternate function did not own the pin");
  a_alt_port_eight: assert property (
    alt_sel[PORT_EIGHT][0] |=> pin_out_r[PORT_EIGHT][0] == $past(alt_out[PORT_EIGHT][0])
                            && pin_oe_r[PORT_EIGHT][0] == $past(alt_oe[PORT_EIGHT][0]))
    else $error("port eight alternate function did not own the pin");
  a_alt_port_nine: assert property (
    alt_sel[PORT_NINE][5] |=> pin_oe_r[PORT_NINE][5] == $past(alt_oe[PORT_NINE][5]))
    else $error("port nine alternate function did not own the pin");
  a_data_write: assert property (
    expand && bus_external && bus_wr |=> pin_oe_r[PORT_TEN] == ALL_PINS
                                     && pin_out_r[PORT_TEN] == $past(bus_wdata_lo))
    else $error("low data byte not driven on write");
  a_data_float: assert property (
    expand && !(bus_external && bus_wr) |=> pin_oe_r[PORT_TEN] == 8'h00)
    else $error("data pins driven outside an external write");
endmodule // pin_function_mux

// ===== src/pin_mux_pkg.sv
/*
  Shared constants for the processor-mode pin function multiplexer:
  port indices, implemented-pin masks, bus pin positions and reset values.
  Assumes a single synchronous clock domain and no register bus.
*/
package pin_mux_pkg;
  // ==========================================================
  // Port geometry
  localparam int NUM_PORTS = 11;
  localparam int PORT_W = 8;
  localparam int PORT_ZERO = 0;
  localparam int PORT_ONE = 1;
  localparam int PORT_TWO = 2;
  localparam int PORT_THREE = 3;
  localparam int PORT_FOUR = 4;
  localparam int PORT_FIVE = 5;
  localparam int PORT_SIX = 6;
  localparam int PORT_SEVEN = 7;
  localparam int PORT_EIGHT = 8;
  localparam int PORT_NINE = 9;
  localparam int PORT_TEN = 10;
  // Pins that exist on the short ports, and the all-pins mask of a full port
  localparam logic [7:0] PORT_TWO_MASK = 8'h8F;
  localparam logic [7:0] PORT_THREE_MASK = 8'h0F;
  localparam logic [7:0] PORT_NINE_MASK = 8'h3F;
  localparam logic [7:0] ALL_PINS = 8'hFF;
  // ==========================================================
  // Bus pin positions
  localparam int ADDR_TOP_PIN = 7;
  localparam int WR_PIN = 0;
  localparam int HIGH_BYTE_PIN = 1;
  localparam int ALE_PIN = 2;
  localparam int GRANT_PIN = 3;
  localparam int HOLD_PIN = 0;
  localparam int READY_PIN = 1;
  localparam int CLK_PIN = 2;
  localparam int CS_LINES = 5;
  localparam int ADDR_HI_PINS = 3;
  // ==========================================================
  // Reset values
  localparam logic [7:0] OE_RST = 8'h00;
  localparam logic [7:0] OUT_RST = 8'h00;
  localparam logic STROBE_N_RST = 1'b1;
  localparam logic HANDSHAKE_N_RST = 1'b1;
  // ==========================================================
  // Processor modes
  typedef enum logic [1:0] {MODE_SINGLE, MODE_EXPAND, MODE_MICRO} mode_t;
endpackage

// ===== sim/ext_bus_model.sv
/*
  Far-side model: external memory and bus handshake partner of the pin mux.
  Assumes driven pins loop back to the pad inputs; undriven pins float.
*/
`timescale 1ns/1ps
module ext_bus_model (
  input wire logic clk_sys,
  input wire logic [pin_mux_pkg::NUM_PORTS-1:0][pin_mux_pkg::PORT_W-1:0] pin_out_r,
  input wire logic [pin_mux_pkg::NUM_PORTS-1:0][pin_mux_pkg::PORT_W-1:0] pin_oe_r,
  input wire logic hold_want,
  input wire logic slow,
  output logic [pin_mux_pkg::NUM_PORTS-1:0][pin_mux_pkg::PORT_W-1:0] pin_in
);
  import pin_mux_pkg::*;
  logic [7:0] noise_r = 8'h00;
  logic mem_sel;
  // ==========================================================
  // Floating pins
  // Moving pattern, so a stale value never passes for a real one
  always @(posedge clk_sys) begin
    noise_r <= noise_r + 8'h3B;
  end
  // Memory is selected by A23 and answers only on a released data byte
  assign mem_sel = pin_oe_r[PORT_TWO][ADDR_TOP_PIN] & pin_out_r[PORT_TWO][ADDR_TOP_PIN];
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      pin_in[p] = (pin_oe_r[p] & pin_out_r[p]) | (~pin_oe_r[p] & noise_r);
    end
    if (mem_sel && pin_oe_r[PORT_TEN] == 8'h00) begin
      pin_in[PORT_TEN] = pin_out_r[PORT_ZERO] ^ 8'h5A;
    end
    // Hold request and a slow ready, both active low
    if (!pin_oe_r[PORT_FOUR][HOLD_PIN]) pin_in[PORT_FOUR][HOLD_PIN] = ~hold_want;
    if (!pin_oe_r[PORT_FOUR][READY_PIN]) pin_in[PORT_FOUR][READY_PIN] = slow;
  end
endmodule // ext_bus_model

// ===== sim/processor_mode_pin_function_mux_tb_top.sv
/*
  Self-checking bench for the pin function multiplexer.
  Assumes ext_bus_model closes the pad loop; notes are checked at negedge.
*/
`timescale 1ns/1ps
`define CMP(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module processor_mode_pin_function_mux_tb_top;
  import pin_mux_pkg::*;
  typedef logic [NUM_PORTS-1:0][PORT_W-1:0] pins_t;
  typedef struct {int sel; logic [7:0] exp; logic [7:0] msk;} note_t;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic mode_pin = 0, exp_req = 0, width_pin = 0, acc = 0, rd = 0, wr = 0, ext = 0;
  logic hbe = 0, ale = 0, grant = 0, clk_lvl = 0, clk_as_port = 0, hi_sel = 0;
  logic hold_want = 0, slow = 0, check_req = 0;
  logic [4:0] cs = '0;
  logic [7:0] wdata = '0;
  logic [23:0] addr = '0;
  pins_t pdata = '0, pdir = '0, asel = '0, aout = '0, aoe = '0, pin_in, pout, poe, pin_r;
  mode_t mode_r;
  logic w16, stb_n, hold_n, rdy_n;
  logic [7:0] rdata;
  int n_fail = 0, total_checks = 0;
  note_t notes[$];
  always #2 clk_sys = ~clk_sys;
  pin_function_mux u_dut (.clk_sys(clk_sys), .resetn(resetn),
    .processor_mode_select_pin(mode_pin), .expansion_mode_req(exp_req),
    .byte_width_pin(width_pin), .port_data(pdata), .port_dir(pdir), .alt_sel(asel),
    .alt_out(aout), .alt_oe(aoe), .bus_addr(addr), .bus_access(acc), .bus_rd(rd),
    .bus_wr(wr), .bus_external(ext), .high_byte_enable(hbe), .bus_ale(ale),
    .bus_release_grant(grant), .sys_clk_level(clk_lvl), .port_four_bit_two_as_port(clk_as_port),
    .addr_hi_sel(hi_sel), .chip_select_lines(cs), .bus_wdata_lo(wdata), .pin_in(pin_in),
    .pin_out_r(pout), .pin_oe_r(poe), .port_in_r(pin_r), .mode_r(mode_r), .bus_16bit_r(w16),
    .enable_strobe_n_r(stb_n), .bus_hold_req_n_r(hold_n), .bus_ready_n_r(rdy_n),
    .bus_rdata_lo_r(rdata));
  ext_bus_model u_mem (.clk_sys(clk_sys), .pin_out_r(pout), .pin_oe_r(poe),
    .hold_want(hold_want), .slow(slow), .pin_in(pin_in));
  // ==========================================================
  // Observation side
  function automatic logic [7:0] obs(int s);
    if (s < 11) return pout[s];
    if (s < 22) return poe[s-11];
    if (s < 33) return pin_r[s-22];
    case (s)
      33: return {6'h00, mode_r};
      34: return {7'h00, w16};
      35: return {7'h00, stb_n};
      36: return {7'h00, hold_n};
      37: return {7'h00, rdy_n};
      default: return rdata;
    endcase
  endfunction
  // Negedge keeps sampling clear of the launching edge
  always @(negedge clk_sys) begin : mon
    note_t n;
    while (check_req && notes.size() > 0) begin
      n = notes.pop_front();
      `CMP($sformatf("item %0d", n.sel), n.exp & n.msk, obs(n.sel) & n.msk)
    end
  end
  // ==========================================================
  // Driver tasks
  task automatic tick(int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic note(int s, logic [7:0] e, logic [7:0] m = 8'hFF);
    notes.push_back('{s, e, m});
  endtask
  task automatic check_now();
    check_req = 1'b1;
    tick(1);
    check_req = 1'b0;
  endtask
  // Mode changes need two edges at the pins and three at the sampled inputs
  task automatic settle(string nm);
    tick(3);
    check_now();
    $display("Test %s done", nm);
  endtask
  task automatic complete_run();
    $display("Checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin : watchdog
    #8000;
    n_fail++;
    complete_run();
  end
  // ==========================================================
  // Test sequence
  initial begin : main
    void'($urandom(46793));
    pdir = '1;
    pdata = '1;
    mode_pin = 1'b1;
    tick(8);
    for (int p = 0; p < NUM_PORTS; p++) note(11 + p, OE_RST);
    note(0, OUT_RST);
    note(33, 8'(MODE_SINGLE));
    note(35, {7'h00, STROBE_N_RST});
    note(36, {7'h00, HANDSHAKE_N_RST});
    check_now();
    $display("Test reset done");
    tick(1);
    resetn = 1'b1;
    tick(1);
    mode_pin = 1'b0;
    acc = 1'b1;
    pdir[0] = 8'($urandom);
    pdata[0] = 8'($urandom);
    asel[7] = '1;
    asel[5] = '1;
    pdir[5] = 8'h00;
    aout[5] = 8'($urandom);
    aoe[5] = 8'($urandom);
    // Analog pins asked to drive, so only the analog override keeps them quiet
    aoe[7] = '1;
    asel[6] = '1;
    aout[6] = 8'($urandom);
    aoe[6] = 8'($urandom);
    asel[8] = '1;
    aout[8] = 8'($urandom);
    aoe[8] = 8'($urandom);
    asel[9] = '1;
    aout[9] = 8'($urandom);
    aoe[9] = 8'($urandom);
    note(0, pdata[0], pdir[0]);
    note(11, pdir[0]);
    note(22, pdata[0], pdir[0]);
    note(16, aoe[5]);
    note(5, aout[5], aoe[5]);
    note(18, 8'h00);
    note(6, aout[6], aoe[6]);
    note(17, aoe[6]);
    note(8, aout[8], aoe[8]);
    note(19, aoe[8]);
    note(9, aout[9], aoe[9] & PORT_NINE_MASK);
    note(20, aoe[9] & PORT_NINE_MASK);
    note(33, 8'(MODE_SINGLE));
    note(35, 8'h00);
    note(36, 8'h01);
    settle("single");
    acc = 1'b0;
    mode_pin = 1'b1;
    addr = {1'b0, 23'($urandom)};
    {wr, hbe, ale, hi_sel, clk_lvl, hold_want, slow} = 7'h7F;
    note(0, addr[7:0]);
    note(11, 8'hFF);
    note(1, addr[15:8]);
    note(12, 8'hFF);
    note(2, {addr[23], 3'h0, addr[19:16]}, PORT_TWO_MASK);
    note(13, PORT_TWO_MASK);
    note(3, 8'h0C, PORT_THREE_MASK);
    note(14, PORT_THREE_MASK);
    note(4, 8'h04, 8'h04);
    note(15, 8'hFC);
    note(36, 8'h00);
    note(37, 8'h01);
    note(9, {5'h00, addr[22:20]}, 8'h07);
    note(20, 8'h07, 8'hC7);
    note(34, 8'h01);
    note(33, 8'(MODE_MICRO));
    settle("micro");
    {wr, rd, ext, slow, hold_want} = 5'h0C;
    addr[23] = 1'b1;
    note(38, addr[7:0] ^ 8'h5A);
    note(21, 8'h00);
    note(35, 8'h00);
    note(37, 8'h00);
    note(36, 8'h01);
    settle("read");
    {rd, wr} = 2'b01;
    wdata = 8'($urandom);
    note(10, wdata);
    note(21, 8'hFF);
    note(35, 8'h01);
    settle("write");
    {wr, ext} = 2'b00;
    tick(2);
    // Width changes only with the bus idle
    {mode_pin, exp_req, width_pin, clk_as_port, clk_lvl, hi_sel} = 6'h1C;
    pdir[4] = 8'h04;
    pdata[4] = 8'h04;
    cs = '1;
    asel[9] = 8'h1F;
    aout[9] = 8'($urandom);
    note(33, 8'(MODE_EXPAND));
    note(34, 8'h00);
    note(4, 8'h04, 8'h04);
    note(15, 8'h04, 8'h04);
    note(9, aout[9], 8'h1F);
    note(20, 8'h1F, 8'hDF);
    settle("expansion");
    clk_as_port = 1'b0;
    note(4, 8'h00, 8'h04);
    note(15, 8'h04, 8'h04);
    settle("clock pin");
    mode_pin = 1'b1;
    tick(3);
    resetn = 1'b0;
    tick(2);
    note(11, 8'h00);
    note(33, 8'(MODE_SINGLE));
    check_now();
    resetn = 1'b1;
    note(33, 8'(MODE_MICRO));
    settle("second reset");
    complete_run();
  end
endmodule // processor_mode_pin_function_mux_tb_top
